// File: design/rsc_sync.sv
// Two-flop synchroniser bank for the remote calibration inputs.
// Assumes the raw inputs may change at any time relative to ref_clk.
`timescale 1ns/10ps
module rsc_sync #(
	parameter int W = 6
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Inputs and outputs
	rsc_sync_if.snk   sif
);
	import rsc_pkg::*;

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= sif.raw;
			sync_r <= meta_r;
		end
	end

	assign sif.synced = sync_r;
endmodule

// File: design/rsc_top.sv
// Remote status outputs and remote calibration request decoding.
// Assumes the state inputs are synchronous to ref_clk; remote inputs are not.
`timescale 1ns/10ps
module rsc_top (
	// Clock and reset
	input  wire logic                           ref_clk,
	input  wire logic                           rst,
	// Instrument state
	input  wire logic                           fault_active,
	input  wire logic                           reading_valid,
	input  wire logic                           auto_range_on,
	input  wire logic                           upper_range_sel,
	input  wire logic                           local_zero_cal,
	input  wire logic                           local_span_cal,
	input  wire logic                           diagnostic_flag_on,
	// Remote inputs, high when the activation level is applied
	input  wire logic [rsc_pkg::REM_WIDTH-1:0]  remote_in,
	// Status outputs, high means conducting
	output logic [rsc_pkg::STAT_WIDTH-1:0]      status_out,
	output logic                                health_ok_flag,
	output logic                                measurement_valid_flag,
	output logic                                upper_range_flag,
	output logic                                lower_range_flag,
	output logic                                zero_calibration_flag,
	output logic                                span_calibration_flag,
	output logic                                diagnostic_flag,
	// Mode display
	output rsc_pkg::rsc_mode_t                  cal_mode,
	output logic                                remote_zero_request,
	output logic                                remote_span_request,
	output logic                                remote_midpoint_request
);
	import rsc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////

	rsc_sync_if #(.W(REM_WIDTH)) sif ();

	// The spare remote bits ride through the bank with the rest so that it stays one
	// width; nothing past the synchroniser reads them.
	assign sif.raw = remote_in;

	rsc_sync #(.W(REM_WIDTH)) u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.sif     (sif)
	);

	logic      rzero;
	logic      rspan;
	logic      rmid;
	rsc_mode_t mode_nxt;
	rsc_mode_t mode_r;

	// A low input is the unpowered case and never requests anything; spare bits are unread.
	assign rzero = sif.synced[REM_ZERO_BIT];
	assign rspan = sif.synced[REM_SPAN_BIT];
	assign rmid  = sif.synced[REM_MID_BIT];

	////////////////////////////////////////////////////////////////////////////////

	// A remote request overrides a local calibration already in progress; the local
	// mode shows again once every contact has opened.
	// Remote requests take priority over local ones; zero beats span beats midpoint so
	// that two contacts closed together still give one well-defined mode.
	always_comb begin
		mode_nxt = RSC_MODE_IDLE;
		if (rzero) begin
			mode_nxt = RSC_MODE_ZERO_R;
		end else if (rspan) begin
			mode_nxt = RSC_MODE_SPAN_R;
		end else if (rmid) begin
			mode_nxt = RSC_MODE_LOW_R;
		end else if (local_zero_cal) begin
			mode_nxt = RSC_MODE_ZERO_L;
		end else if (local_span_cal) begin
			mode_nxt = RSC_MODE_SPAN_L;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_r <= RSC_MODE_IDLE;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign cal_mode = mode_r;

	// The request outputs mirror the synchronised contacts, so the mode display can
	// tell which remote calibration is in force even when a local one is pending.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			remote_zero_request <= 1'b0;
		end else begin
			remote_zero_request <= rzero;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			remote_span_request <= 1'b0;
		end else begin
			remote_span_request <= rspan;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			remote_midpoint_request <= 1'b0;
		end else begin
			remote_midpoint_request <= rmid;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Status outputs. Each condition has its own flop, so the isolated outputs change
	// only on a clock edge and a glitch on one input never disturbs another.
	logic health_r;
	logic valid_r;
	logic upper_r;
	logic lower_r;
	logic zero_r;
	logic span_r;
	logic diag_r;
	logic in_zero;
	logic in_span;

	// The calibration flags decode the next mode rather than mode_r, so they change on
	// the same edge as cal_mode and never disagree with it for a cycle.
	// Midpoint calibration is a span calibration, so it lights the span flag.
	always_comb begin
		in_zero = (mode_nxt == RSC_MODE_ZERO_R) || (mode_nxt == RSC_MODE_ZERO_L);
		in_span = (mode_nxt == RSC_MODE_SPAN_R) || (mode_nxt == RSC_MODE_SPAN_L) ||
			(mode_nxt == RSC_MODE_LOW_R);
	end

	// Reset clears every output, so the controller sees no health and no valid
	// reading until the first edge after release.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			health_r <= STAT_RESET[STAT_HEALTH_BIT];
		end else begin
			health_r <= ~fault_active;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			valid_r <= STAT_RESET[STAT_VALID_BIT];
		end else begin
			valid_r <= reading_valid;
		end
	end

	// Outside auto ranging neither range flag is lit, because a fixed range has no
	// position worth reporting.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			upper_r <= STAT_RESET[STAT_UPPER_BIT];
		end else begin
			upper_r <= auto_range_on & upper_range_sel;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lower_r <= STAT_RESET[STAT_LOWER_BIT];
		end else begin
			lower_r <= auto_range_on & ~upper_range_sel;
		end
	end

	// The calibration flags follow the decoded mode, which already carries the
	// remote priority, so they cannot report a mode that is not in force.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			zero_r <= STAT_RESET[STAT_ZERO_BIT];
		end else begin
			zero_r <= in_zero;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			span_r <= STAT_RESET[STAT_SPAN_BIT];
		end else begin
			span_r <= in_span;
		end
	end

	// Diagnostic mode is reported as given; this block does not judge whether the
	// instrument may enter it.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			diag_r <= STAT_RESET[STAT_DIAG_BIT];
		end else begin
			diag_r <= diagnostic_flag_on;
		end
	end

	// The spare position is tied off here rather than left to the register reset, so
	// it stays off whatever the reset pattern becomes.
	always_comb begin
		status_out                  = STAT_RESET;
		status_out[STAT_HEALTH_BIT] = health_r;
		status_out[STAT_VALID_BIT]  = valid_r;
		status_out[STAT_UPPER_BIT]  = upper_r;
		status_out[STAT_LOWER_BIT]  = lower_r;
		status_out[STAT_ZERO_BIT]   = zero_r;
		status_out[STAT_SPAN_BIT]   = span_r;
		status_out[STAT_DIAG_BIT]   = diag_r;
		status_out[STAT_SPARE_BIT]  = 1'b0;
	end

	assign health_ok_flag         = health_r;
	assign measurement_valid_flag = valid_r;
	assign upper_range_flag       = upper_r;
	assign lower_range_flag       = lower_r;
	assign zero_calibration_flag  = zero_r;
	assign span_calibration_flag  = span_r;
	assign diagnostic_flag        = diag_r;
endmodule

// File: shared/rsc_pkg.sv
// Constants for the remote status and calibration request block.
// Assumes one system clock; status outputs are open-collector transistors outside the core.
package rsc_pkg;

	// Status output bit positions.
	localparam int STAT_WIDTH      = 8;
	localparam int STAT_HEALTH_BIT = 0;
	localparam int STAT_VALID_BIT  = 1;
	localparam int STAT_UPPER_BIT  = 2;
	localparam int STAT_ZERO_BIT   = 3;
	localparam int STAT_SPAN_BIT   = 4;
	localparam int STAT_DIAG_BIT   = 5;
	localparam int STAT_LOWER_BIT  = 6;
	localparam int STAT_SPARE_BIT  = 7;

	// Remote input bit positions.
	localparam int REM_WIDTH    = 6;
	localparam int REM_ZERO_BIT = 0;
	localparam int REM_SPAN_BIT = 1;
	localparam int REM_MID_BIT  = 2;

	localparam logic [STAT_WIDTH-1:0] STAT_RESET = 8'h00;
	localparam logic [REM_WIDTH-1:0]  REM_RESET  = 6'h00;

	// Calibration mode reported on the mode display.
	typedef enum logic [2:0] {
		RSC_MODE_IDLE     = 3'b000,
		RSC_MODE_ZERO_L   = 3'b001,
		RSC_MODE_SPAN_L   = 3'b010,
		RSC_MODE_ZERO_R   = 3'b011,
		RSC_MODE_SPAN_R   = 3'b100,
		RSC_MODE_LOW_R    = 3'b101
	} rsc_mode_t;

endpackage

// File: shared/rsc_sync_if.sv
// Carries raw and synchronised remote inputs between the top and its synchroniser.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface rsc_sync_if #(parameter int W = 6);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport src (output raw, input synced);
	modport snk (input raw, output synced);
endinterface

// File: test/rsc_plc_model.sv
// Contact model of the remote controller.
// Assumes the bench picks the energized contacts.
`timescale 1ns/10ps
module rsc_plc_model (
	// Contacts and spare wiring
	input  wire logic [2:0] con,
	input  wire logic [2:0] sp,
	// Analyzer remote inputs
	output logic      [5:0] remote_in
);
	// An open contact leaves its input unpowered, so it reads low.
	assign remote_in = {sp, con};
endmodule

// File: test/rsc_top_assertions.sv
// Port checker for rsc_top.
// Assumes it is bound to every rsc_top instance.
`timescale 1ns/10ps
module rsc_top_assertions (
	// Clock and reset
	input wire logic                           ref_clk,
	input wire logic                           rst,
	// Instrument state
	input wire logic                           fault_active,
	input wire logic                           reading_valid,
	input wire logic                           auto_range_on,
	input wire logic                           upper_range_sel,
	input wire logic                           diagnostic_flag_on,
	// Remote inputs
	input wire logic [rsc_pkg::REM_WIDTH-1:0]  remote_in,
	// Outputs under check
	input wire logic [rsc_pkg::STAT_WIDTH-1:0] status_out,
	input rsc_pkg::rsc_mode_t                  cal_mode,
	input wire logic                           health_ok_flag,
	input wire logic                           remote_zero_request,
	input wire logic                           remote_span_request,
	input wire logic                           remote_midpoint_request
);
	import rsc_pkg::*;

	logic [1:0] n_r;

	// All checks but a_spare wait three edges so the pipeline holds no reset leftovers.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			n_r <= 2'h0;
		end else if (n_r != 2'h3) begin
			n_r <= n_r + 2'h1;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////

	property p_health;
		n_r == 2'h3 |-> health_ok_flag == !$past(fault_active);
	endproperty
	a_health: assert property (p_health) else $error("health flag wrong");

	property p_valid;
		n_r == 2'h3 |-> status_out[STAT_VALID_BIT] == $past(reading_valid);
	endproperty
	a_valid: assert property (p_valid) else $error("valid flag wrong");

	property p_up;
		n_r == 2'h3 |-> status_out[STAT_UPPER_BIT] == $past(auto_range_on && upper_range_sel);
	endproperty
	a_up: assert property (p_up) else $error("upper range flag wrong");

	property p_lo;
		n_r == 2'h3 |-> status_out[STAT_LOWER_BIT] == $past(auto_range_on && !upper_range_sel);
	endproperty
	a_lo: assert property (p_lo) else $error("lower range flag wrong");

	property p_diag;
		n_r == 2'h3 |-> status_out[STAT_DIAG_BIT] == $past(diagnostic_flag_on);
	endproperty
	a_diag: assert property (p_diag) else $error("diagnostic flag wrong");

	property p_zero;
		n_r == 2'h3 && $past(remote_in[REM_ZERO_BIT], 3) |->
			status_out[STAT_ZERO_BIT] && cal_mode == RSC_MODE_ZERO_R;
	endproperty
	a_zero: assert property (p_zero) else $error("remote zero not in force");

	property p_span;
		n_r == 2'h3 && $past(remote_in[1:0], 3) == 2'h2 |->
			status_out[STAT_SPAN_BIT] && cal_mode == RSC_MODE_SPAN_R;
	endproperty
	a_span: assert property (p_span) else $error("remote span not in force");

	property p_low;
		n_r == 2'h3 && $past(remote_in[2:0], 3) == 3'h4 |->
			status_out[STAT_SPAN_BIT] && cal_mode == RSC_MODE_LOW_R;
	endproperty
	a_low: assert property (p_low) else $error("remote low not in force");

	property p_sync;
		n_r == 2'h3 |->
			{remote_midpoint_request, remote_span_request, remote_zero_request} ==
			$past(remote_in[2:0], 3);
	endproperty
	a_sync: assert property (p_sync) else $error("request outputs wrong");

	property p_spare;
		!status_out[STAT_SPARE_BIT];
	endproperty
	a_spare: assert property (p_spare) else $error("spare output on");
endmodule

bind rsc_top rsc_top_assertions chk (
	.ref_clk                 (ref_clk),
	.rst                     (rst),
	.fault_active            (fault_active),
	.reading_valid           (reading_valid),
	.auto_range_on           (auto_range_on),
	.upper_range_sel         (upper_range_sel),
	.diagnostic_flag_on            (diagnostic_flag_on),
	.remote_in               (remote_in),
	.status_out              (status_out),
	.cal_mode                (cal_mode),
	.health_ok_flag          (health_ok_flag),
	.remote_zero_request     (remote_zero_request),
	.remote_span_request     (remote_span_request),
	.remote_midpoint_request (remote_midpoint_request)
);

// File: test/test_rsc_top.sv
// Random self-checking bench for rsc_top.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/10ps
module test_rsc_top;
	import rsc_pkg::*;
	logic            ref_clk, rst;
	logic      [6:0] st, st_p, fl;
	logic      [2:0] con, sp, rq;
	logic      [5:0] remote_in;
	logic      [2:0] rh [0:2];
	logic      [7:0] status_out;
	rsc_mode_t       cal_mode, em;
	int              err_count = 0, checks_done = 0, seed, warm = 0;
	rsc_plc_model plc (.con(con), .sp(sp), .remote_in(remote_in));
	rsc_top dut (.ref_clk(ref_clk), .rst(rst), .fault_active(st[6]), .reading_valid(st[5]),
		.auto_range_on(st[4]), .upper_range_sel(st[3]), .local_zero_cal(st[2]),
		.local_span_cal(st[1]), .diagnostic_flag_on(st[0]), .remote_in(remote_in),
		.status_out(status_out), .health_ok_flag(fl[0]), .measurement_valid_flag(fl[1]),
		.upper_range_flag(fl[2]), .zero_calibration_flag(fl[3]), .span_calibration_flag(fl[4]),
		.diagnostic_flag(fl[5]), .lower_range_flag(fl[6]), .cal_mode(cal_mode),
		.remote_zero_request(rq[0]), .remote_span_request(rq[1]), .remote_midpoint_request(rq[2]));
	////////////////////////////////
	function automatic rsc_mode_t exp_mode(input logic [2:0] r, input logic lz, input logic ls);
		if (r[0]) return RSC_MODE_ZERO_R;
		if (r[1]) return RSC_MODE_SPAN_R;
		if (r[2]) return RSC_MODE_LOW_R;
		if (lz) return RSC_MODE_ZERO_L;
		if (ls) return RSC_MODE_SPAN_L;
		return RSC_MODE_IDLE;
	endfunction
	function automatic logic [7:0] exp_stat(input logic [6:0] p, input rsc_mode_t m);
		return {1'b0, p[4] & ~p[3], p[0], m == RSC_MODE_SPAN_L || m >= RSC_MODE_SPAN_R,
			m == RSC_MODE_ZERO_L || m == RSC_MODE_ZERO_R, p[4] & p[3], p[5], ~p[6]};
	endfunction
	task automatic chk(input logic ok, input string s);
		checks_done++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, s);
		end
	endtask
	task automatic summarize();
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		seed = 32'h682d;
		{rst, st, con, sp} = 14'h2000;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		// A short reset in mid-run checks that the pipeline restarts cleanly.
		for (int i = 0; i < 3000; i++) begin
			@(posedge ref_clk);
			st_p = st;
			rh[2] = rh[1];
			rh[1] = rh[0];
			rh[0] = remote_in[2:0];
			warm++;
			rst <= (i >= 1500 && i < 1503);
			if (i >= 100 && i < 132) begin
				// Every contact pattern held four cycles, against all-ones and all-zero state.
				st  <= (i % 2 != 0) ? 7'h7f : 7'h00;
				sp  <= 3'h7;
				con <= 3'(i >> 2);
			end else begin
				st <= 7'($random(seed));
				sp <= 3'($random(seed));
				if ($random(seed) % 4 == 0) begin
					con <= 3'($random(seed));
				end
			end
			@(negedge ref_clk);
			em = exp_mode(rh[2], st_p[2], st_p[1]);
			if (rst) begin
				warm = 0;
				chk(status_out === 8'h00 && cal_mode === RSC_MODE_IDLE, "reset");
			end else if (warm > 3) begin
				chk(status_out === exp_stat(st_p, em), "status");
				chk(cal_mode === em && rq === rh[2], "mode");
				chk(fl === status_out[6:0], "flags");
			end
		end
		summarize();
	end
endmodule
